// >>> core/dtc_pkg.sv
package dtc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_CMP0 = 8'h08;
    localparam logic [7:0] OFS_CMP1 = 8'h0c;
    localparam logic [7:0] OFS_DUTY0 = 8'h10;
    localparam logic [7:0] OFS_DUTY1 = 8'h14;
    localparam logic [7:0] OFS_COUNT = 8'h18;
    // Control register fields
    localparam int CTL_FF = 7;
    localparam int CTL_CKS_HI = 6;
    localparam int CTL_CKS_LO = 4;
    localparam int CTL_RUN = 3;
    localparam int CTL_MODE_HI = 2;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CMP_RST = 8'hff;
    localparam logic [7:0] DUTY_RST = 8'h80;
    // Clock select codes
    localparam logic [2:0] CKS_DIV11 = 3'h0;
    localparam logic [2:0] CKS_DIV7 = 3'h1;
    localparam logic [2:0] CKS_DIV5 = 3'h2;
    localparam logic [2:0] CKS_DIV3 = 3'h3;
    localparam logic [2:0] CKS_FS = 3'h4;
    localparam logic [2:0] CKS_DIV1 = 3'h5;
    localparam logic [2:0] CKS_FC = 3'h6;
    localparam logic [2:0] CKS_PIN = 3'h7;
    // Timing: system clock and slow clock rates
    localparam int CLK_HZ = 100000000;
    localparam int FS_HZ = 32768;
    localparam int FS_DIV = CLK_HZ / FS_HZ;
    localparam logic [11:0] FS_LAST = 12'(FS_DIV - 1);
    // Operating modes
    typedef enum logic [2:0] {
        MODE_TIMER = 3'h0,
        MODE_PDO = 3'h1,
        MODE_PWM = 3'h2,
        MODE_16LO = 3'h3,
        MODE_16HI = 3'h4
    } dtc_mode_type;
endpackage

// >>> core/dtc_timer.sv
`timescale 1ns/100ps
// Operation
// R01: Event mode counts pin falling edges; match raises irq, clears, continues.
// R02: External source holds each pin level at least two clock cycles.
// R03: Software keeps flip-flop init bit zero in timer and event modes.
// R04: Compare register unbuffered, write acts at once; not changed while running.
// R05: Divider mode counts internal clock; match toggles, clears, raises irq.
// R06: Divider pin is inverse flip-flop; software presets it; reset clears it.
// R07: Stopping holds pin level; flip-flop changed only by a later write.
// R08: Control bit 3 runs channel; bit 7 sets flip-flop, zero drives pin high.
// R09: Software sets the port output latch before using the output pins.
// R10: PWM duty match toggles; overflow toggles, clears, raises irq.
// R11: PWM pin is inverse flip-flop; preset chooses polarity; reset clears it.
// R12: Duty double-buffered: running write moves at match irq, stopped at once.
// R13: Reading duty while running returns the active stage, not new write.
// R14: Software writes duty right after the match irq, avoiding the transfer.
// R15: Stopping PWM holds pin; flip-flop changed only after the stop.
// R16: Software stops the PWM channel before entering STOP mode.
// R17: Cascaded 16-bit timer runs on upper run bit; match irq, clear, continue.
// R18: Software writes compare low byte first, then high byte, never only one.
// R19: Control value 11h selects fc/2^7 divider mode; 19h also starts it.
// R20: 16-bit mode: lower control 13h, upper control 04h then 0Ch to start.
// R21: Cascaded counting takes its clock from the lower channel select field.
// R22: In 8-bit modes both channels run fully independently.
module dtc_timer (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] event_input_pin,
    input wire logic prescaler_source_select,
    output logic [1:0] divider_out_pin,
    output logic [1:0] pwm_out_pin,
    output logic [1:0] channel_match_irq,
    output logic upper_match_irq
);
    logic [7:0] ctrl_r [2], cmp_r [2], cnt_r [2], cnt_nxt [2], inc [2];
    logic [7:0] duty_buf_r [2], duty_act_r [2], duty_act_nxt [2];
    logic [1:0] pin_r, pin_nxt, irq_r, irq_nxt, evt_prev_r, evt_fall;
    logic [1:0] tick, run, wr_ctrl, wr_cmp, wr_duty;
    logic [10:0] pre_r;
    logic [11:0] fs_cnt_r;
    logic [2:0] fs_pre_r;
    logic fs_tick, fs8_tick, casc, pready_r, pslverr_r, rd_err, acc;
    logic [15:0] c16_inc, c16_cmp;
    logic [31:0] prdata_r, rd_nxt;

    // Source clock tick for one channel
    function automatic logic tick_sel(input logic [2:0] sel,
                                      input logic [10:0] pre,
                                      input logic fsd, input logic fs1,
                                      input logic div11, input logic fall);
        case (sel)
            dtc_pkg::CKS_DIV11: tick_sel = div11 ? fsd : (&pre);
            dtc_pkg::CKS_DIV7: tick_sel = &pre[6:0];
            dtc_pkg::CKS_DIV5: tick_sel = &pre[4:0];
            dtc_pkg::CKS_DIV3: tick_sel = &pre[2:0];
            dtc_pkg::CKS_FS: tick_sel = fs1;
            dtc_pkg::CKS_DIV1: tick_sel = pre[0];
            dtc_pkg::CKS_FC: tick_sel = 1'b1;
            default: tick_sel = fall;
        endcase
    endfunction

    // APB decode
    assign acc = psel && penable && pready_r;
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            wr_ctrl[c] = acc && pwrite && !pslverr_r &&
                         paddr == (c == 0 ? dtc_pkg::OFS_CTRL0
                                          : dtc_pkg::OFS_CTRL1);
            wr_cmp[c] = acc && pwrite && !pslverr_r &&
                        paddr == (c == 0 ? dtc_pkg::OFS_CMP0
                                         : dtc_pkg::OFS_CMP1);
            wr_duty[c] = acc && pwrite && !pslverr_r &&
                         paddr == (c == 0 ? dtc_pkg::OFS_DUTY0
                                          : dtc_pkg::OFS_DUTY1);
        end
    end

    // Read mux, captured in the setup cycle
    always_comb begin
        rd_nxt = 32'h00000000;
        rd_err = 1'b0;
        case (paddr)
            dtc_pkg::OFS_CTRL0: rd_nxt[7:0] = ctrl_r[0];
            dtc_pkg::OFS_CTRL1: rd_nxt[7:0] = ctrl_r[1];
            dtc_pkg::OFS_CMP0: rd_nxt[7:0] = cmp_r[0];
            dtc_pkg::OFS_CMP1: rd_nxt[7:0] = cmp_r[1];
            dtc_pkg::OFS_DUTY0: rd_nxt[7:0] = duty_act_r[0]; // see R13
            dtc_pkg::OFS_DUTY1: rd_nxt[7:0] = duty_act_r[1]; // see R13
            dtc_pkg::OFS_COUNT: rd_nxt[15:0] = {cnt_r[1], cnt_r[0]};
            default: rd_err = 1'b1;
        endcase
    end

    // APB answer, no wait states
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= psel && !penable;
            if (psel && !penable) begin
                prdata_r <= pwrite ? 32'h00000000 : rd_nxt;
                pslverr_r <= rd_err;
            end
        end
    end

    // Software registers; compare writes act at once
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int c = 0; c < 2; c++) begin
                ctrl_r[c] <= dtc_pkg::CTRL_RST;
                cmp_r[c] <= dtc_pkg::CMP_RST;
                duty_buf_r[c] <= dtc_pkg::DUTY_RST;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (wr_ctrl[c]) ctrl_r[c] <= pwdata[7:0]; // see R08, R19, R20
                if (wr_cmp[c]) cmp_r[c] <= pwdata[7:0]; // see R04
                if (wr_duty[c]) duty_buf_r[c] <= pwdata[7:0]; // see R12
            end
        end
    end

    // Prescaler, slow clock divider, event edge detect
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pre_r <= 11'h000;
            fs_cnt_r <= 12'h000;
            fs_pre_r <= 3'h0;
            evt_prev_r <= 2'h3;
        end else begin
            pre_r <= pre_r + 11'h001;
            fs_cnt_r <= fs_tick ? 12'h000 : fs_cnt_r + 12'h001;
            if (fs_tick) fs_pre_r <= fs_pre_r + 3'h1;
            evt_prev_r <= event_input_pin;
        end
    end
    assign fs_tick = fs_cnt_r == dtc_pkg::FS_LAST;
    assign fs8_tick = fs_tick && (&fs_pre_r);
    assign evt_fall = evt_prev_r & ~event_input_pin; // see R01

    // Channel clocks and run state
    assign casc = ctrl_r[0][2:0] == dtc_pkg::MODE_16LO &&
                  ctrl_r[1][2:0] == dtc_pkg::MODE_16HI;
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            tick[c] = tick_sel(ctrl_r[c][dtc_pkg::CTL_CKS_HI:
                                         dtc_pkg::CTL_CKS_LO],
                               pre_r, fs8_tick, fs_tick,
                               prescaler_source_select, evt_fall[c]);
            run[c] = ctrl_r[c][dtc_pkg::CTL_RUN];
            inc[c] = cnt_r[c] + 8'h01;
        end
    end
    assign c16_inc = {cnt_r[1], cnt_r[0]} + 16'h0001;
    assign c16_cmp = {cmp_r[1], cmp_r[0]};

    // Counter, flip-flop and duty next state
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            cnt_nxt[c] = cnt_r[c];
            pin_nxt[c] = pin_r[c];
            irq_nxt[c] = 1'b0;
            duty_act_nxt[c] = duty_act_r[c];
            if (!casc && !run[c]) begin
                cnt_nxt[c] = 8'h00; // see R08
            end else if (!casc && tick[c]) begin // see R22
                case (dtc_pkg::dtc_mode_type'(ctrl_r[c][2:0]))
                    dtc_pkg::MODE_TIMER, dtc_pkg::MODE_PDO: begin
                        if (inc[c] == cmp_r[c]) begin // see R01, R05
                            cnt_nxt[c] = 8'h00;
                            irq_nxt[c] = 1'b1;
                            if (ctrl_r[c][2:0] == dtc_pkg::MODE_PDO)
                                pin_nxt[c] = !pin_r[c]; // see R05
                        end else begin
                            cnt_nxt[c] = inc[c];
                        end
                    end
                    dtc_pkg::MODE_PWM: begin
                        if (cnt_r[c] == 8'hff) begin // see R10
                            cnt_nxt[c] = 8'h00;
                            irq_nxt[c] = 1'b1;
                            pin_nxt[c] = !pin_r[c];
                            duty_act_nxt[c] = duty_buf_r[c]; // see R12
                        end else begin
                            cnt_nxt[c] = inc[c];
                            if (inc[c] == duty_act_r[c])
                                pin_nxt[c] = !pin_r[c]; // see R10
                        end
                    end
                    default: cnt_nxt[c] = 8'h00;
                endcase
            end
            // Preset only while stopped, so a stopping write holds the pin
            if (wr_ctrl[c] && !run[c])
                pin_nxt[c] = !pwdata[dtc_pkg::CTL_FF]; // see R06, R07, R15
            if (wr_duty[c] && !run[c])
                duty_act_nxt[c] = pwdata[7:0]; // see R12
        end
        // Cascaded 16-bit timer on the lower channel clock
        if (casc) begin
            if (!run[1]) begin
                cnt_nxt[0] = 8'h00;
                cnt_nxt[1] = 8'h00;
            end else if (tick[0]) begin // see R21
                if (c16_inc == c16_cmp) begin // see R17
                    cnt_nxt[0] = 8'h00;
                    cnt_nxt[1] = 8'h00;
                    irq_nxt[1] = 1'b1;
                end else begin
                    cnt_nxt[0] = c16_inc[7:0];
                    cnt_nxt[1] = c16_inc[15:8];
                end
            end
        end
    end

    // Counter, flip-flop and interrupt state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int c = 0; c < 2; c++) begin
                cnt_r[c] <= 8'h00;
                duty_act_r[c] <= dtc_pkg::DUTY_RST;
            end
            pin_r <= 2'h3; // see R06, R11
            irq_r <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                cnt_r[c] <= cnt_nxt[c];
                duty_act_r[c] <= duty_act_nxt[c];
            end
            pin_r <= pin_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Outputs straight from flops
    assign divider_out_pin = pin_r; // see R06
    assign pwm_out_pin = pin_r; // see R11
    assign channel_match_irq = irq_r;
    assign upper_match_irq = irq_r[1];
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // Checks
    sequence s_ev_step;
        !casc && run[1] && ctrl_r[1][2:0] == dtc_pkg::MODE_TIMER &&
        tick[1] && inc[1] != cmp_r[1];
    endsequence
    property p_event_count;
        @(posedge clk) disable iff (reset)
        s_ev_step |=> cnt_r[1] == $past(cnt_r[1]) + 8'h01;
    endproperty
    a_event_count: assert property (p_event_count) // see R01
        else $error("event counter did not advance");
    sequence s_pdo_match;
        !casc && run[0] && ctrl_r[0][2:0] == dtc_pkg::MODE_PDO &&
        tick[0] && inc[0] == cmp_r[0] && !wr_ctrl[0];
    endsequence
    property p_pdo_toggle;
        @(posedge clk) disable iff (reset)
        s_pdo_match |=> pin_r[0] != $past(pin_r[0]) && cnt_r[0] == 8'h00
            && irq_r[0];
    endproperty
    a_pdo_toggle: assert property (p_pdo_toggle) // see R05
        else $error("divider match did not toggle and clear");
    property p_preset;
        @(posedge clk) disable iff (reset)
        wr_ctrl[0] && !run[0] |=> pin_r[0] == !$past(pwdata[7]);
    endproperty
    a_preset: assert property (p_preset) // see R06
        else $error("flip-flop preset not applied");
    // Stop write, then a stopped cycle with no preset
    sequence s_stop;
        wr_ctrl[0] && run[0] && !pwdata[dtc_pkg::CTL_RUN] ##1
        !run[0] && !wr_ctrl[0];
    endsequence
    property p_stop_hold;
        @(posedge clk) disable iff (reset)
        s_stop |=> $stable(pin_r[0]);
    endproperty
    a_stop_hold: assert property (p_stop_hold) // see R07
        else $error("pin changed after stop");
    property p_stopped_idle;
        @(posedge clk) disable iff (reset)
        !casc && !run[0] [*2] |-> cnt_r[0] == 8'h00 && !irq_r[0];
    endproperty
    a_stopped_idle: assert property (p_stopped_idle) // see R08
        else $error("stopped channel still counting");
    property p_pwm_ovf;
        @(posedge clk) disable iff (reset)
        !casc && run[0] && ctrl_r[0][2:0] == dtc_pkg::MODE_PWM && tick[0]
            && cnt_r[0] == 8'hff && !wr_ctrl[0] |=>
            irq_r[0] && cnt_r[0] == 8'h00 && pin_r[0] != $past(pin_r[0])
            && duty_act_r[0] == $past(duty_buf_r[0]);
    endproperty
    a_pwm_ovf: assert property (p_pwm_ovf) // see R10, R12
        else $error("pwm overflow handling wrong");
    property p_duty_hold;
        @(posedge clk) disable iff (reset)
        run[0] && !irq_nxt[0] |=> $stable(duty_act_r[0]);
    endproperty
    a_duty_hold: assert property (p_duty_hold) // see R13
        else $error("active duty changed without match");
    property p_duty_direct;
        @(posedge clk) disable iff (reset)
        wr_duty[0] && !run[0] |=> duty_act_r[0] == $past(pwdata[7:0]);
    endproperty
    a_duty_direct: assert property (p_duty_direct) // see R12
        else $error("stopped duty write not transferred");
    property p_c16_match;
        @(posedge clk) disable iff (reset)
        casc && run[1] && tick[0] && c16_inc == c16_cmp |=>
            irq_r[1] && !irq_r[0] && {cnt_r[1], cnt_r[0]} == 16'h0000;
    endproperty
    a_c16_match: assert property (p_c16_match) // see R17
        else $error("16-bit match not handled");
    property p_start_pdo;
        @(posedge clk) disable iff (reset)
        wr_ctrl[0] && pwdata[7:0] == 8'h19 |=> run[0] &&
            ctrl_r[0][2:0] == dtc_pkg::MODE_PDO &&
            ctrl_r[0][6:4] == dtc_pkg::CKS_DIV7;
    endproperty
    a_start_pdo: assert property (p_start_pdo) // see R19
        else $error("control start value not decoded");
endmodule

// >>> verification/dtc_event_src.sv
`timescale 1ns/100ps
// Far side: pulse source on the upper event pin, idle high
module dtc_event_src (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [7:0] count,
    input wire logic [3:0] hold,
    output logic busy,
    output logic [1:0] event_input_pin
);
    logic [8:0] edges_r;
    logic [3:0] hold_r;

    // Each level stands hold+1 cycles, under two only when hold is zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy <= 1'b0;
            edges_r <= 9'h000;
            hold_r <= 4'h0;
            event_input_pin <= 2'b11;
        end else if (start && !busy) begin
            busy <= 1'b1;
            edges_r <= {count, 1'b0};
            hold_r <= hold;
        end else if (busy) begin
            if (hold_r != 4'h0) begin
                hold_r <= hold_r - 4'h1;
            end else if (edges_r == 9'h000) begin
                busy <= 1'b0;
            end else begin
                event_input_pin[1] <= ~event_input_pin[1];
                edges_r <= edges_r - 9'h001;
                hold_r <= hold;
            end
        end
    end
endmodule

// >>> verification/dual_timer_counter_modes_tb.sv
`timescale 1ns/100ps
module dual_timer_counter_modes_tb;
    logic clk, reset, psel, penable, pwrite, pss, start, busy, e;
    logic pready, pslverr, upper_irq;
    logic [7:0] paddr, count, duty, nd;
    logic [3:0] hold;
    logic [31:0] pwdata, prdata, q;
    logic [1:0] evt, pdo, pwm, irq, hv;
    int n_errors = 0, num_checks = 0, seed, k, i;
    int n_irq0 = 0, n_irq1 = 0, n_up = 0, n_lo = 0, n_lp = 0;
    int a0, a1, au, alo, alp;

    dtc_timer dut (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_input_pin(evt),
        .prescaler_source_select(pss), .divider_out_pin(pdo),
        .pwm_out_pin(pwm), .channel_match_irq(irq),
        .upper_match_irq(upper_irq));

    dtc_event_src src (.clk(clk), .reset(reset), .start(start),
        .count(count), .hold(hold), .busy(busy),
        .event_input_pin(evt));

    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Running tallies of pulses and low pin cycles
    always @(posedge clk) begin
        n_irq0 <= n_irq0 + int'(irq[0] === 1'b1);
        n_irq1 <= n_irq1 + int'(irq[1] === 1'b1);
        n_up <= n_up + int'(upper_irq === 1'b1);
        n_lo <= n_lo + int'(pdo[0] === 1'b0);
        n_lp <= n_lp + int'(pwm[0] === 1'b0);
    end

    task close_out;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            n_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, s, x);
        end
    endtask

    task hang;
        n_errors++;
        $display("ERROR %0t: wait ran out", $time);
        close_out;
    endtask

    // One APB transfer, entered just after a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) hang;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let an edge pass before the next setup
        @(posedge clk);
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask

    task rd(input logic [7:0] a, input logic [7:0] x);
        apb(1'b0, a, 32'h00000000);
        chk(q, {24'h000000, x});
    endtask

    task wirq(input int ch);
        for (k = 0; k < 1000; k++) begin
            @(posedge clk);
            if (irq[ch] === 1'b1) break;
        end
        if (k == 1000) hang;
    endtask

    task window(input int n);
        a0 = n_irq0;
        a1 = n_irq1;
        au = n_up;
        alo = n_lo;
        alp = n_lp;
        repeat (n) @(posedge clk);
    endtask

    // Expected low cycles of the PWM pin over two periods
    function automatic int pwm_low(input logic [7:0] d);
        return 2 * (256 - int'(d));
    endfunction

    initial begin
        seed = 32'h7448;
        reset = 1'b1;
        {psel, penable, pwrite, pss, start} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        count = 8'h00;
        hold = 4'h1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk(pdo, 2'b11);
        chk(pwm, 2'b11);
        rd(dtc_pkg::OFS_CTRL0, dtc_pkg::CTRL_RST);
        rd(dtc_pkg::OFS_CMP1, dtc_pkg::CMP_RST);
        rd(dtc_pkg::OFS_DUTY0, dtc_pkg::DUTY_RST);
        apb(1'b0, 8'h1c, 32'h00000000);
        chk(q, 32'h00000000);
        chk({31'h00000000, e}, 32'h00000001);
        // Divider at clk/128, compare of one
        wr(dtc_pkg::OFS_CMP0, 8'h01);
        wr(dtc_pkg::OFS_CTRL0, 8'h11);
        rd(dtc_pkg::OFS_CTRL0, 8'h11);
        wr(dtc_pkg::OFS_CTRL0, 8'h19);
        wirq(0);
        window(512);
        chk(n_irq0 - a0, 4);
        chk(n_irq1 - a1, 0);
        // Stop holds the pin, then presets while stopped
        wr(dtc_pkg::OFS_CTRL0, 8'h11);
        @(posedge clk);
        hv = pdo;
        window(300);
        chk(pdo, hv);
        chk(n_irq0 - a0, 0);
        wr(dtc_pkg::OFS_CTRL0, 8'h91);
        repeat (2) @(posedge clk);
        chk({pdo[0], pwm[0]}, 2'b00);
        wr(dtc_pkg::OFS_CTRL0, 8'h11);
        repeat (2) @(posedge clk);
        chk(pdo[0], 1'b1);
        // Fast divider: toggle every two cycles
        wr(dtc_pkg::OFS_CMP0, 8'h02);
        wr(dtc_pkg::OFS_CTRL0, 8'h69);
        wirq(0);
        window(40);
        chk(n_irq0 - a0, 20);
        chk(n_lo - alo, 20);
        wr(dtc_pkg::OFS_CTRL0, 8'h61);
        // Event counting on the upper channel
        wr(dtc_pkg::OFS_CMP1, 8'h03);
        wr(dtc_pkg::OFS_CTRL1, 8'h78);
        a1 = n_irq1;
        count <= 8'h09;
        hold <= 4'(1 + $unsigned($random(seed)) % 6);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (2) @(posedge clk);
        for (i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk);
        if (i == 2000) hang;
        repeat (4) @(posedge clk);
        chk(n_irq1 - a1, 3);
        chk(pdo[1], 1'b1);
        wr(dtc_pkg::OFS_CTRL1, 8'h70);
        // PWM: stopped write moves at once, then corners and random
        duty = 8'h02;
        wr(dtc_pkg::OFS_CTRL0, 8'h62);
        wr(dtc_pkg::OFS_DUTY0, duty);
        rd(dtc_pkg::OFS_DUTY0, duty);
        wr(dtc_pkg::OFS_CTRL0, 8'h6a);
        wirq(0);
        window(512);
        chk(n_lp - alp, pwm_low(duty));
        chk(n_irq0 - a0, 2);
        for (int t = 0; t < 3; t++) begin
            nd = (t == 0) ? 8'hfe : 8'(2 + $unsigned($random(seed)) % 253);
            wirq(0);
            wr(dtc_pkg::OFS_DUTY0, nd);
            rd(dtc_pkg::OFS_DUTY0, duty);
            wirq(0);
            duty = nd;
            rd(dtc_pkg::OFS_DUTY0, duty);
            window(512);
            chk(n_lp - alp, pwm_low(duty));
        end
        wr(dtc_pkg::OFS_CTRL0, 8'h62);
        @(posedge clk);
        hv = pwm;
        window(300);
        chk(pwm, hv);
        wr(dtc_pkg::OFS_CTRL0, 8'h62);
        repeat (2) @(posedge clk);
        chk(pwm[0], 1'b1);
        // Cascaded 16-bit timer, low byte first
        wr(dtc_pkg::OFS_CTRL0, 8'h00);
        wr(dtc_pkg::OFS_CMP0, 8'h03);
        wr(dtc_pkg::OFS_CMP1, 8'h00);
        wr(dtc_pkg::OFS_CTRL0, 8'h13);
        wr(dtc_pkg::OFS_CTRL1, 8'h04);
        wr(dtc_pkg::OFS_CTRL1, 8'h0c);
        wirq(1);
        window(768);
        chk(n_up - au, 2);
        chk(n_irq1 - a1, 2);
        chk(n_irq0 - a0, 0);
        close_out;
    end
endmodule
